// >>> verilog/dis_init_seq.sv
// Functional notes
// - Any reset clears the init command mode field to 000.
// - Clock enables held low while reset is active.
// - Clock enables stay low until mode written nonzero, then all rise together.
// - Suspend entry flushes pending commands, then puts all rows in self-refresh.
// - Resume resets the block: mode cleared, clock enables low until nonzero write.
// - Mode 001: every DRAM cycle issues a NOP.
// - Mode 010: every DRAM cycle issues precharge all banks.
// - Mode 011: mode register set, host address 13:3 onto memory address.
// - Mode 100: extended mode register set, same address mapping.
// - Mode 110: every DRAM cycle issues a CBR refresh.
// - Mode 111 normal reads and writes; 101 reserved, nothing issued.
// - Memory type field read-only, reports DDR code 01.
`timescale 1ns/1ps
`default_nettype none
module dis_init_seq
    import dis_pkg::*;
#(
    parameter int CKE_W = 4
)
(
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RST_N_IN,
    input  wire logic                   REG_WR_IN,
    input  wire logic                   REG_RD_IN,
    input  wire logic [7:0]             REG_ADDR_IN,
    input  wire logic [3:0]             REG_BE_IN,
    input  wire logic [31:0]            REG_WDATA_IN,
    output var  logic [31:0]            REG_RDATA_OUT,
    input  wire logic                   HOST_REQ_IN,
    input  wire logic                   HOST_WR_IN,
    input  wire logic [31:0]            HOST_ADDR_IN,
    input  wire logic [63:0]            HOST_WDATA_IN,
    output var  logic                   HOST_DONE_OUT,
    output var  logic [63:0]            HOST_RDATA_OUT,
    input  wire logic                   SUSPEND_IN,
    output var  logic                   SELF_REFRESH_OUT,
    output var  logic [CKE_W-1:0]       CKE_OUT,
    output var  logic                   CMD_VALID_OUT,
    output var  logic                   CS_N_OUT,
    output var  logic                   RAS_N_OUT,
    output var  logic                   CAS_N_OUT,
    output var  logic                   WE_N_OUT,
    output var  logic [1:0]             BANK_OUT,
    output var  logic [DIS_MA_W-1:0]    MEMORY_ADDRESS_OUT,
    output var  logic                   FAST_CHIP_SELECT_ENABLE_OUT
)
;
    typedef enum logic [3:0]
    {
        S_RUN   = 4'h1,
        S_FLUSH = 4'h2,
        S_SREF  = 4'h4,
        S_IN_SR = 4'h8
    } dis_pst_type;

    typedef struct packed
    {
        logic [31:0]         mode_reg;
        logic [CKE_W-1:0]    cke;
        dis_pst_type         pst;
        logic [1:0]          susp_sync;
        logic                pending;
        logic                host_wr;
        logic [31:0]         host_addr;
        logic                host_done;
        logic [63:0]         rdata;
        logic [31:0]         reg_rdata;
        logic                sref;
        logic                cmd_valid;
        dis_cmd_type         cmd;
        logic [1:0]          bank;
        logic [DIS_MA_W-1:0] ma;
    } dis_top_type;

    dis_top_type s_q, s_d;
    dis_cmd_if   cif ();

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_be

    dis_cmd_gen u_gen
    (
        .clk   (CLOCK_IN),
        .rst_n (RST_N_IN),
        .cif   (cif)
    );

    // No new request while the generator reports done
    assign cif.req   = s_q.pending && !cif.busy && !cif.done
                       && (s_q.pst == S_RUN);
    assign cif.wr    = s_q.host_wr;
    assign cif.addr  = s_q.host_addr;
    assign cif.mode  = dis_icm_type'(s_q.mode_reg[DIS_ICM_LSB +: 3]);
    assign cif.flush = (s_q.pst != S_RUN);

    always_comb
    begin
        logic [2:0]  old_icm;
        logic [31:0] nv;
        old_icm     = s_q.mode_reg[DIS_ICM_LSB +: 3];
        nv          = s_q.mode_reg;
        s_d         = s_q;
        s_d.host_done = 1'b0;
        s_d.susp_sync = {s_q.susp_sync[0], SUSPEND_IN};
        if (REG_WR_IN && REG_ADDR_IN == DIS_MODE_REG_OFFSET)
        begin
            nv = merge_be(s_q.mode_reg, REG_WDATA_IN, REG_BE_IN);
            nv = (nv & DIS_MODE_WMASK) | (s_q.mode_reg & ~DIS_MODE_WMASK);
            nv[DIS_MEM_TYPE_LSB +: 2] = DIS_MEM_TYPE_DDR;
            s_d.mode_reg = nv;
            if (old_icm == DIS_ICM_RESET && nv[DIS_ICM_LSB +: 3] != DIS_ICM_RESET)
            begin
                s_d.cke = '1;
            end
        end
        if (REG_RD_IN)
        begin
            if (REG_ADDR_IN == DIS_MODE_REG_OFFSET)
            begin
                s_d.reg_rdata = s_q.mode_reg;
            end
            else
            begin
                s_d.reg_rdata = '0;
            end
        end
        // Request still high in the done cycle is not a new cycle
        if (HOST_REQ_IN && !s_q.pending
            && !s_q.host_done)
        begin
            s_d.pending   = 1'b1;
            s_d.host_wr   = HOST_WR_IN;
            s_d.host_addr = HOST_ADDR_IN;
        end
        if (cif.req && cif.mode == DIS_ICM_RSVD)
        begin
            s_d.pending   = 1'b0;
            s_d.host_done = 1'b1;
        end
        if (cif.done)
        begin
            s_d.pending   = 1'b0;
            s_d.host_done = 1'b1;
            s_d.rdata     = s_q.host_wr ? s_q.rdata : HOST_WDATA_IN;
        end
        s_d.cmd_valid = cif.valid;
        s_d.cmd       = cif.cmd;
        s_d.bank      = cif.bank;
        s_d.ma        = cif.ma;
        case (s_q.pst)
            S_RUN:
            begin
                if (s_q.susp_sync[1])
                begin
                    s_d.pst = S_FLUSH;
                end
            end
            S_FLUSH:
            begin
                s_d.pending = 1'b0;
                if (!cif.busy)
                begin
                    s_d.pst = S_SREF;
                end
            end
            S_SREF:
            begin
                s_d.cmd_valid = 1'b1;
                s_d.cmd       = DIS_CMD_REF;
                s_d.cke       = '0;
                s_d.sref      = 1'b1;
                s_d.pst       = S_IN_SR;
            end
            S_IN_SR:
            begin
                s_d.cke = '0;
                s_d.pending = 1'b0;
            end
            default: s_d.pst = S_RUN;
        endcase
        if (!RST_N_IN)
        begin
            s_d          = '0;
            s_d.mode_reg = DIS_MODE_REG_RESET;
            s_d.cke      = '0;
            s_d.pst      = S_RUN;
            s_d.cmd      = DIS_CMD_DESEL;
        end
    end

    always_ff @(posedge CLOCK_IN)
    begin
        s_q <= s_d;
    end

    assign REG_RDATA_OUT               = s_q.reg_rdata;
    assign HOST_DONE_OUT               = s_q.host_done;
    assign HOST_RDATA_OUT              = s_q.rdata;
    assign SELF_REFRESH_OUT            = s_q.sref;
    assign CKE_OUT                     = s_q.cke;
    assign CMD_VALID_OUT               = s_q.cmd_valid;
    assign {CS_N_OUT, RAS_N_OUT, CAS_N_OUT, WE_N_OUT} = s_q.cmd;
    assign BANK_OUT                    = s_q.bank;
    assign MEMORY_ADDRESS_OUT          = s_q.ma;
    assign FAST_CHIP_SELECT_ENABLE_OUT = s_q.mode_reg[DIS_FCS_BIT];
endmodule : dis_init_seq
`default_nettype wire

// >>> verilog/dis_pkg.sv
package dis_pkg;
    // Register offset, byte address range 0x68..0x6b
    localparam logic [7:0]  DIS_MODE_REG_OFFSET = 8'h68;
    localparam logic [31:0] DIS_MODE_REG_RESET  = 32'h00000001;
    // Field positions
    localparam int DIS_MEM_TYPE_LSB = 0;
    localparam int DIS_ICM_LSB   = 4;
    localparam int DIS_FCS_BIT   = 7;
    localparam int DIS_CHAN_LSB  = 21;
    localparam int DIS_IC_BIT    = 29;
    localparam int DIS_RMS_LSB   = 8;
    // Writable bit mask: 29, 22:21, 10:8, 7, 6:4
    localparam logic [31:0] DIS_MODE_WMASK = 32'h206007f0;
    localparam logic [1:0]  DIS_MEM_TYPE_DDR = 2'h1;
    // Host address to memory address mapping for mode register set
    localparam int DIS_HOST_ADDR_LSB = 3;
    localparam int DIS_HOST_ADDR_MSB = 13;
    localparam int DIS_MA_LSB        = 1;

    typedef enum logic [2:0]
    {
        DIS_ICM_RESET  = 3'h0,
        DIS_ICM_NOP    = 3'h1,
        DIS_ICM_PREALL = 3'h2,
        DIS_ICM_MRS    = 3'h3,
        DIS_ICM_EMRS   = 3'h4,
        DIS_ICM_RSVD   = 3'h5,
        DIS_ICM_CBR    = 3'h6,
        DIS_ICM_NORMAL = 3'h7
    } dis_icm_type;

    // DRAM command encoding {cs_n, ras_n, cas_n, we_n}
    typedef enum logic [3:0]
    {
        DIS_CMD_DESEL  = 4'hf,
        DIS_CMD_NOP    = 4'h7,
        DIS_CMD_PRE    = 4'h2,
        DIS_CMD_MRS    = 4'h0,
        DIS_CMD_REF    = 4'h1,
        DIS_CMD_ACT    = 4'h3,
        DIS_CMD_RD     = 4'h5,
        DIS_CMD_WR     = 4'h4
    } dis_cmd_type;

    localparam logic [1:0] DIS_BA_MRS  = 2'h0;
    localparam logic [1:0] DIS_BA_EMRS = 2'h1;
    localparam int         DIS_MA_W    = 13;
    localparam int         DIS_AP_BIT  = 10;
endpackage : dis_pkg

// >>> verilog/dis_cmd_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dis_cmd_if;
    import dis_pkg::*;
    logic                  req;
    logic                  wr;
    logic [31:0]           addr;
    dis_icm_type           mode;
    logic                  flush;
    logic                  busy;
    logic                  done;
    logic                  valid;
    dis_cmd_type           cmd;
    logic [1:0]            bank;
    logic [DIS_MA_W-1:0]   ma;
    modport ctrl (output req, output wr, output addr, output mode, output flush,
                  input busy, input done, input valid, input cmd, input bank, input ma);
    modport seq  (input req, input wr, input addr, input mode, input flush,
                  output busy, output done, output valid, output cmd, output bank,
                  output ma);
endinterface : dis_cmd_if
`default_nettype wire

// >>> verilog/dis_cmd_gen.sv
`timescale 1ns/1ps
`default_nettype none
module dis_cmd_gen
    import dis_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    dis_cmd_if.seq     cif
);
    typedef enum logic [3:0]
    {
        G_IDLE = 4'h1,
        G_ACT  = 4'h2,
        G_ACC  = 4'h4,
        G_DONE = 4'h8
    } dis_gst_type;

    typedef struct packed
    {
        dis_gst_type         st;
        logic                valid;
        dis_cmd_type         cmd;
        logic [1:0]          bank;
        logic [DIS_MA_W-1:0] ma;
        logic                done;
        logic                wr;
        logic [31:0]         addr;
    } dis_gen_type;

    dis_gen_type s_q, s_d;

    function automatic logic [DIS_MA_W-1:0] map_mrs(input logic [31:0] a);
        logic [DIS_MA_W-1:0] m;
        m = '0;
        m[DIS_MA_LSB +: (DIS_HOST_ADDR_MSB-DIS_HOST_ADDR_LSB+1)] =
            a[DIS_HOST_ADDR_MSB:DIS_HOST_ADDR_LSB];
        return m;
    endfunction : map_mrs

    always_comb
    begin
        s_d       = s_q;
        s_d.valid = 1'b0;
        s_d.done  = 1'b0;
        s_d.cmd   = DIS_CMD_DESEL;
        case (s_q.st)
            G_IDLE:
            begin
                if (cif.req && !cif.flush)
                begin
                    s_d.valid = 1'b1;
                    s_d.wr    = cif.wr;
                    s_d.addr  = cif.addr;
                    s_d.bank  = '0;
                    s_d.ma    = '0;
                    s_d.st    = G_DONE;
                    case (cif.mode)
                        DIS_ICM_NOP:    s_d.cmd = DIS_CMD_NOP;
                        DIS_ICM_PREALL:
                        begin
                            s_d.cmd                = DIS_CMD_PRE;
                            s_d.ma[DIS_AP_BIT]     = 1'b1;
                        end
                        DIS_ICM_MRS:
                        begin
                            s_d.cmd  = DIS_CMD_MRS;
                            s_d.bank = DIS_BA_MRS;
                            s_d.ma   = map_mrs(cif.addr);
                        end
                        DIS_ICM_EMRS:
                        begin
                            s_d.cmd  = DIS_CMD_MRS;
                            s_d.bank = DIS_BA_EMRS;
                            s_d.ma   = map_mrs(cif.addr);
                        end
                        DIS_ICM_CBR:    s_d.cmd = DIS_CMD_REF;
                        DIS_ICM_NORMAL:
                        begin
                            s_d.cmd  = DIS_CMD_ACT;
                            s_d.bank = cif.addr[14:13];
                            s_d.ma   = cif.addr[27:15];
                            s_d.st   = G_ACT;
                        end
                        default:
                        begin
                            s_d.valid = 1'b0;
                            s_d.st    = G_IDLE;
                        end
                    endcase
                end
            end
            G_ACT:
            begin
                s_d.valid = 1'b1;
                s_d.cmd   = s_q.wr ? DIS_CMD_WR : DIS_CMD_RD;
                s_d.ma    = {3'h0, s_q.addr[12:3]};
                s_d.st    = G_DONE;
            end
            G_DONE:
            begin
                s_d.done = 1'b1;
                s_d.st   = G_IDLE;
            end
            default: s_d.st = G_IDLE;
        endcase
        if (!rst_n)
        begin
            s_d      = '0;
            s_d.st   = G_IDLE;
            s_d.cmd  = DIS_CMD_DESEL;
        end
    end

    always_ff @(posedge clk)
    begin
        s_q <= s_d;
    end

    assign cif.busy  = (s_q.st != G_IDLE);
    assign cif.done  = s_q.done;
    assign cif.valid = s_q.valid;
    assign cif.cmd   = s_q.cmd;
    assign cif.bank  = s_q.bank;
    assign cif.ma    = s_q.ma;
endmodule : dis_cmd_gen
`default_nettype wire

// >>> testbench/dis_dimm_model.sv
`timescale 1ns/1ps
`default_nettype none
module dis_dimm_model
    import dis_pkg::*;
(
    input  wire logic                clk_in,
    input  wire logic                valid_in,
    input  wire logic [3:0]          cmd_in,
    input  wire logic [1:0]          bank_in,
    input  wire logic [DIS_MA_W-1:0] addr_in,
    output var  logic [3:0]          last_cmd_out,
    output var  logic [1:0]          last_bank_out,
    output var  logic [DIS_MA_W-1:0] last_addr_out,
    output var  logic [15:0]         n_cmd_out
);
    initial
    begin
        last_cmd_out = 4'hf;
        last_bank_out = 2'h3;
        last_addr_out = '1;
        n_cmd_out = 16'h0;
    end

    // Latch every command the memory sees
    always @(posedge clk_in)
    begin
        if (valid_in === 1'b1)
        begin
            last_cmd_out <= cmd_in;
            last_bank_out <= bank_in;
            last_addr_out <= addr_in;
            n_cmd_out <= n_cmd_out + 16'h1;
        end
    end
endmodule : dis_dimm_model
`default_nettype wire

// >>> testbench/dis_init_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dis_init_seq_checker
    import dis_pkg::*;
#(
    parameter int CKE_W = 4
)
(
    input wire logic                CLOCK_IN,
    input wire logic                RST_N_IN,
    input wire logic                REG_WR_IN,
    input wire logic [7:0]          REG_ADDR_IN,
    input wire logic [3:0]          REG_BE_IN,
    input wire logic [31:0]         REG_WDATA_IN,
    input wire logic [31:0]         HOST_ADDR_IN,
    input wire logic                SUSPEND_IN,
    input wire logic                HOST_DONE_OUT,
    input wire logic                SELF_REFRESH_OUT,
    input wire logic [CKE_W-1:0]    CKE_OUT,
    input wire logic                CMD_VALID_OUT,
    input wire logic                CS_N_OUT,
    input wire logic                RAS_N_OUT,
    input wire logic                CAS_N_OUT,
    input wire logic                WE_N_OUT,
    input wire logic [1:0]          BANK_OUT,
    input wire logic [DIS_MA_W-1:0] MEMORY_ADDRESS_OUT
);
    logic [3:0] cmd;
    logic       icm_wr;
    assign cmd = {CS_N_OUT, RAS_N_OUT, CAS_N_OUT, WE_N_OUT};
    assign icm_wr = REG_WR_IN && REG_ADDR_IN == DIS_MODE_REG_OFFSET && REG_BE_IN[0]
                    && REG_WDATA_IN[6:4] != 3'h0;
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_cke_reset_low: assert property (disable iff (1'b0) !RST_N_IN |=> CKE_OUT == '0)
        else $error("clock enable high after reset cycle");
    a_cke_all_equal: assert property (CKE_OUT == '0 || CKE_OUT == '1)
        else $error("clock enables differ");
    a_cke_rise_cause: assert property ($rose(CKE_OUT[0]) |-> $past(icm_wr))
        else $error("clock enable rose without nonzero mode write");
    a_done_one_pulse: assert property (HOST_DONE_OUT |=> !HOST_DONE_OUT)
        else $error("done longer than one cycle");
    a_mrs_addr_map: assert property (CMD_VALID_OUT && cmd == DIS_CMD_MRS |->
        MEMORY_ADDRESS_OUT == {1'b0, HOST_ADDR_IN[13:3], 1'b0} && BANK_OUT <= 2'h1)
        else $error("mode register command operand wrong");
    a_pre_all_banks: assert property (CMD_VALID_OUT && cmd == DIS_CMD_PRE |->
        MEMORY_ADDRESS_OUT[DIS_AP_BIT]) else $error("precharge not all banks");
    a_cmd_then_done: assert property (CMD_VALID_OUT && CKE_OUT != '0 &&
        cmd != DIS_CMD_ACT |=> HOST_DONE_OUT) else $error("no done after command");
    a_sr_entry_cmd: assert property ($rose(SELF_REFRESH_OUT) |->
        CMD_VALID_OUT && cmd == DIS_CMD_REF && CKE_OUT == '0)
        else $error("self refresh entry malformed");
    a_suspend_to_sr: assert property ($rose(SUSPEND_IN) |-> ##[1:20] SELF_REFRESH_OUT)
        else $error("self refresh not reached");
endmodule : dis_init_seq_checker
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dis_pkg::*;
    logic        CLOCK_IN, RST_N_IN, REG_WR_IN, REG_RD_IN, HOST_REQ_IN, HOST_WR_IN;
    logic        SUSPEND_IN, HOST_DONE_OUT, SELF_REFRESH_OUT, CMD_VALID_OUT;
    logic        CS_N_OUT, RAS_N_OUT, CAS_N_OUT, WE_N_OUT, FAST_CHIP_SELECT_ENABLE_OUT;
    logic [7:0]  REG_ADDR_IN;
    logic [3:0]  REG_BE_IN, CKE_OUT, last_cmd;
    logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, HOST_ADDR_IN, rd, a, seed;
    logic [63:0] HOST_WDATA_IN, HOST_RDATA_OUT;
    logic [1:0]  BANK_OUT, last_bank;
    logic [12:0] MEMORY_ADDRESS_OUT, last_ma;
    logic [15:0] n_cmd, n0;
    logic [2:0]  modes [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
    int          errors = 0;
    int          n_checks = 0;
    int          k;

    dis_init_seq dut (.CLOCK_IN, .RST_N_IN, .REG_WR_IN, .REG_RD_IN, .REG_ADDR_IN, .REG_BE_IN,
        .REG_WDATA_IN, .REG_RDATA_OUT, .HOST_REQ_IN, .HOST_WR_IN, .HOST_ADDR_IN,
        .HOST_WDATA_IN, .HOST_DONE_OUT, .HOST_RDATA_OUT, .SUSPEND_IN, .SELF_REFRESH_OUT,
        .CKE_OUT, .CMD_VALID_OUT, .CS_N_OUT, .RAS_N_OUT, .CAS_N_OUT, .WE_N_OUT, .BANK_OUT,
        .MEMORY_ADDRESS_OUT, .FAST_CHIP_SELECT_ENABLE_OUT);
    dis_dimm_model dimm (.clk_in(CLOCK_IN), .valid_in(CMD_VALID_OUT),
        .cmd_in({CS_N_OUT, RAS_N_OUT, CAS_N_OUT, WE_N_OUT}), .bank_in(BANK_OUT),
        .addr_in(MEMORY_ADDRESS_OUT), .last_cmd_out(last_cmd), .last_bank_out(last_bank),
        .last_addr_out(last_ma), .n_cmd_out(n_cmd));

    function automatic logic [3:0] exp_cmd(input logic [2:0] m);
        case (m)
            3'h1: return DIS_CMD_NOP;
            3'h2: return DIS_CMD_PRE;
            3'h6: return DIS_CMD_REF;
            default: return DIS_CMD_MRS;
        endcase
    endfunction : exp_cmd

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic reg_wr(input logic [31:0] d, input logic [3:0] be);
        REG_WR_IN <= 1'b1;
        REG_ADDR_IN <= DIS_MODE_REG_OFFSET;
        REG_WDATA_IN <= d;
        REG_BE_IN <= be;
        @(posedge CLOCK_IN);
        REG_WR_IN <= 1'b0;
        @(posedge CLOCK_IN);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] ad);
        REG_RD_IN <= 1'b1;
        REG_ADDR_IN <= ad;
        @(posedge CLOCK_IN);
        REG_RD_IN <= 1'b0;
        @(posedge CLOCK_IN);
        rd = REG_RDATA_OUT;
    endtask : reg_rd

    task automatic host_cyc(input logic [31:0] ad, input logic w);
        int t;
        t = 0;
        HOST_REQ_IN <= 1'b1;
        HOST_ADDR_IN <= ad;
        HOST_WR_IN <= w;
        HOST_WDATA_IN <= {ad, ~ad};
        do
        begin
            @(posedge CLOCK_IN);
            t++;
        end
        while (HOST_DONE_OUT !== 1'b1 && t < 20);
        HOST_REQ_IN <= 1'b0;
        check("done", 32'h1, HOST_DONE_OUT);
        @(posedge CLOCK_IN);
    endtask : host_cyc

    initial
    begin
        CLOCK_IN = 1'b0;
        forever #25 CLOCK_IN = ~CLOCK_IN;
    end

    initial
    begin
        repeat (5000) @(posedge CLOCK_IN);
        errors++;
        finish_test();
    end

    initial
    begin
        seed = 32'hd77843ed;
        RST_N_IN = 1'b0;
        REG_WR_IN = 1'b0;
        REG_RD_IN = 1'b0;
        REG_ADDR_IN = 8'h0;
        REG_BE_IN = 4'h0;
        REG_WDATA_IN = 32'h0;
        HOST_REQ_IN = 1'b0;
        HOST_WR_IN = 1'b0;
        HOST_ADDR_IN = 32'h0;
        HOST_WDATA_IN = 64'h0;
        SUSPEND_IN = 1'b0;
        repeat (8) @(posedge CLOCK_IN);
        RST_N_IN <= 1'b1;
        @(posedge CLOCK_IN);
        reg_rd(8'h68);
        check("mode_reg", DIS_MODE_REG_RESET, rd);
        check("cke_reset", 32'h0, CKE_OUT);
        reg_rd(8'h6c);
        check("unmapped", 32'h0, rd);
        reg_wr(32'h13, 4'h0);
        reg_wr(32'h2, 4'h1);
        reg_rd(8'h68);
        check("type_ro", DIS_MODE_REG_RESET, rd);
        check("cke_hold", 32'h0, CKE_OUT);
        foreach (modes[i])
        begin
            reg_wr({25'h0, modes[i], 4'h0}, 4'h1);
            check("cke_on", 32'hf, CKE_OUT);
            repeat (2)
            begin
                a = $random(seed);
                n0 = n_cmd;
                host_cyc(a, a[0]);
                check("cmd", exp_cmd(modes[i]), last_cmd);
                check("one_cmd", n0 + 16'h1, n_cmd);
                if (modes[i] == 3'h3 || modes[i] == 3'h4)
                begin
                    check("ma", {1'b0, a[13:3], 1'b0}, last_ma);
                    check("bank", {1'b0, modes[i] == 3'h4}, last_bank);
                end
            end
        end
        reg_wr(32'h50, 4'h1);
        n0 = n_cmd;
        host_cyc(a, 1'b0);
        check("rsvd", n0, n_cmd);
        reg_wr(32'h70, 4'h1);
        host_cyc(a, 1'b0);
        check("read", DIS_CMD_RD, last_cmd);
        check("rdata", ~a, HOST_RDATA_OUT[31:0]);
        host_cyc(a, 1'b1);
        check("write", DIS_CMD_WR, last_cmd);
        check("n_norm", n0 + 16'h4, n_cmd);
        reg_rd(8'h68);
        check("mode_rd", 32'h71, rd);
        SUSPEND_IN <= 1'b1;
        k = 0;
        while (SELF_REFRESH_OUT !== 1'b1 && k < 40)
        begin
            @(posedge CLOCK_IN);
            k++;
        end
        @(posedge CLOCK_IN);
        check("sr", 32'h1, SELF_REFRESH_OUT);
        check("sr_cke", 32'h0, CKE_OUT);
        check("sr_cmd", DIS_CMD_REF, last_cmd);
        RST_N_IN <= 1'b0;
        repeat (2) @(posedge CLOCK_IN);
        SUSPEND_IN <= 1'b0;
        RST_N_IN <= 1'b1;
        @(posedge CLOCK_IN);
        reg_rd(8'h68);
        check("resume_mode", DIS_MODE_REG_RESET, rd);
        check("resume_cke", 32'h0, CKE_OUT);
        reg_wr(32'h10, 4'h1);
        check("resume_on", 32'hf, CKE_OUT);
        host_cyc(a, 1'b0);
        check("resume_nop", DIS_CMD_NOP, last_cmd);
        check("fcs", 32'h0, FAST_CHIP_SELECT_ENABLE_OUT);
        finish_test();
    end
endmodule : tb_top

bind dis_init_seq dis_init_seq_checker #(.CKE_W(CKE_W)) u_chk (.CLOCK_IN, .RST_N_IN,
    .REG_WR_IN, .REG_ADDR_IN, .REG_BE_IN, .REG_WDATA_IN, .HOST_ADDR_IN, .SUSPEND_IN,
    .HOST_DONE_OUT, .SELF_REFRESH_OUT, .CKE_OUT, .CMD_VALID_OUT, .CS_N_OUT, .RAS_N_OUT,
    .CAS_N_OUT, .WE_N_OUT, .BANK_OUT, .MEMORY_ADDRESS_OUT);
`default_nettype wire
